/* verilog/hpp_host_port.sv */
`timescale 1ns/1ps
module hpp_host_port
(
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [1:0]  host_adr_in,
  input  wire logic [31:0] host_data_in,
  output logic      [31:0] host_data_out,
  output logic      [31:0] host_data_oe_out,
  input  wire logic        host_cs_n_in,
  input  wire logic        host_wr_n_in,
  input  wire logic        host_rd_n_in,
  input  wire logic        low_word_enable_n_in,
  input  wire logic        high_word_enable_n_in,
  output logic             host_ack_n_out,
  input  wire logic        fifo_full_in,
  input  wire logic        fifo_empty_in,
  input  wire logic        encode_mode_in,
  input  wire logic [31:0] fifo_rd_data_in,
  output logic             fifo_push_out,
  output logic             fifo_pop_out,
  output logic [31:0]      fifo_wr_data_out,
  output logic [8:0]       fifo_ptr_out,
  output logic [7:0]       ind_ptr_out
);
  // Two-flop synchronisers for every asynchronous host pin.
  logic [38:0] sync1_q;
  logic [38:0] sync2_q;
  logic [31:0] data_s;
  logic [1:0]  adr_s;
  logic        cs_n_s;
  logic        wr_n_s;
  logic        rd_n_s;
  logic        lwe_n_s;
  logic        hwe_n_s;
  always_ff @(posedge ref_clk_in)
  begin
    sync1_q <= {host_data_in, host_adr_in, host_cs_n_in, host_wr_n_in, host_rd_n_in,
                low_word_enable_n_in, high_word_enable_n_in};
    sync2_q <= sync1_q;
  end
  assign {data_s, adr_s, cs_n_s, wr_n_s, rd_n_s, lwe_n_s, hwe_n_s} = sync2_q;

  // Write data as last seen while the strobe was still low. The host may change
  // the data together with the strobe release, so the word beside the edge is stale.
  logic [31:0] data_q;
  always_ff @(posedge ref_clk_in)
  begin
    data_q <= data_s;
  end

  logic sel;
  logic wr_act;
  logic rd_act;
  logic lo_act;
  logic hi_act;
  assign sel = !cs_n_s;
  assign wr_act = sel && !wr_n_s;
  assign rd_act = sel && !rd_n_s;
  assign lo_act = sel && !lwe_n_s;
  assign hi_act = sel && !hwe_n_s;

  logic wr_act_q;
  logic lo_act_q;
  logic hi_act_q;
  logic [1:0] adr_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_act_q <= 1'b0;
      lo_act_q <= 1'b0;
      hi_act_q <= 1'b0;
      adr_q    <= hpp_pkg::ADR_DIRECT0;
    end
    else
    begin
      wr_act_q <= wr_act;
      lo_act_q <= lo_act;
      hi_act_q <= hi_act;
      if (sel)
        adr_q <= adr_s;
    end
  end
  logic wr_rise;
  logic lo_rel;
  logic hi_rel;
  logic fifo_blocked;
  assign wr_rise = wr_act_q && !wr_act;
  assign lo_rel = lo_act_q && !lo_act;
  assign hi_rel = hi_act_q && !hi_act;
  assign fifo_blocked = (adr_s == hpp_pkg::ADR_FIFO) &&
                        (encode_mode_in ? fifo_empty_in : fifo_full_in);

  // Direct locations; the FIFO location only stages its write word here.
  logic [31:0] loc_q [hpp_pkg::NUM_LOC];
  genvar gi;
  generate
    for (gi = 0; gi < hpp_pkg::NUM_LOC; gi++)
    begin : g_loc
      always_ff @(posedge ref_clk_in)
      begin
        if (sys_rst_in)
          loc_q[gi] <= hpp_pkg::LOC_RESET;
        else if (wr_rise && adr_q == 2'(gi))
        begin
          if (lo_act_q)
            loc_q[gi][15:0] <= data_q[15:0];
          if (hi_act_q)
            loc_q[gi][31:16] <= data_q[31:16];
        end
      end
    end
  endgenerate

  logic [8:0] fifo_ptr_q;
  logic [7:0] ind_ptr_q;
  logic fifo_step;
  logic ind_step;
  assign fifo_step = hi_rel && adr_q == hpp_pkg::ADR_FIFO;
  assign ind_step = lo_rel && adr_q == hpp_pkg::ADR_INDIRECT_DATA;
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      fifo_ptr_q <= hpp_pkg::FIFO_PTR_RESET;
    else if (fifo_step)
      fifo_ptr_q <= fifo_ptr_q + hpp_pkg::FIFO_PTR_STEP;
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      ind_ptr_q <= hpp_pkg::IND_PTR_RESET;
    else if (adr_q == hpp_pkg::ADR_INDIRECT_ADDR && wr_rise && lo_act_q)
      ind_ptr_q <= data_q[7:0];
    else if (ind_step)
      ind_ptr_q <= ind_ptr_q + hpp_pkg::IND_PTR_STEP;
  end
  assign fifo_ptr_out = fifo_ptr_q;
  assign ind_ptr_out = ind_ptr_q;

  logic fifo_push_q;
  logic fifo_pop_q;
  logic [31:0] fifo_wr_data_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      fifo_push_q    <= 1'b0;
      fifo_pop_q     <= 1'b0;
      fifo_wr_data_q <= hpp_pkg::LOC_RESET;
    end
    else
    begin
      fifo_push_q    <= fifo_step && !encode_mode_in;
      fifo_pop_q     <= fifo_step && encode_mode_in;
      fifo_wr_data_q <= loc_q[hpp_pkg::ADR_FIFO];
    end
  end
  assign fifo_push_out = fifo_push_q;
  assign fifo_pop_out = fifo_pop_q;
  assign fifo_wr_data_out = fifo_wr_data_q;

  // Read data and bus drive come from flops; drive stops as soon as select drops.
  logic [31:0] rd_data_q;
  logic [31:0] oe_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      rd_data_q <= hpp_pkg::LOC_RESET;
      oe_q      <= hpp_pkg::LOC_RESET;
    end
    else
    begin
      rd_data_q <= (adr_s == hpp_pkg::ADR_FIFO) ? fifo_rd_data_in : loc_q[adr_s];
      oe_q      <= {{16{rd_act && hi_act}}, {16{rd_act && lo_act}}};
    end
  end
  assign host_data_out = rd_data_q;
  assign host_data_oe_out = sel ? oe_q : hpp_pkg::LOC_RESET;

  // The acknowledge takes one wait cycle, which covers read data settling on the bus.
  hpp_pkg::hpp_state_t state_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      state_q <= hpp_pkg::HPP_IDLE;
    else
    begin
      case (state_q)
        hpp_pkg::HPP_IDLE:
          if ((wr_act || rd_act) && !fifo_blocked)
            state_q <= hpp_pkg::HPP_WAIT;
        hpp_pkg::HPP_WAIT:
          state_q <= hpp_pkg::HPP_ACK;
        hpp_pkg::HPP_ACK:
          if (!wr_act && !rd_act)
            state_q <= hpp_pkg::HPP_IDLE;
        default:
          state_q <= hpp_pkg::HPP_IDLE;
      endcase
    end
  end
  assign host_ack_n_out = !(state_q == hpp_pkg::HPP_ACK);

  a_tristate_cs: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cs_n_s |-> host_data_oe_out == 32'h0000_0000)
    else $error("data driven while deselected");
  a_fifo_adv: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (fifo_ptr_q != $past(fifo_ptr_q)) |-> $past(hi_rel && adr_q == hpp_pkg::ADR_FIFO))
    else $error("fifo pointer moved without upper word release");
  a_ind_adv: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ind_step |=> ind_ptr_q == $past(ind_ptr_q) + 8'h01)
    else $error("indirect pointer did not step");
  a_ack_block: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_q == hpp_pkg::HPP_IDLE && fifo_blocked) |=> state_q == hpp_pkg::HPP_IDLE)
    else $error("access taken while fifo blocked");
  a_ack_timing: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_q == hpp_pkg::HPP_IDLE && (wr_act || rd_act) && !fifo_blocked)
      |=> ##1 !host_ack_n_out)
    else $error("ack not two cycles after access");
  a_ignore_cs: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (cs_n_s && state_q == hpp_pkg::HPP_IDLE) |=> state_q == hpp_pkg::HPP_IDLE)
    else $error("access taken without select");
  a_write_lo: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (wr_rise && lo_act_q && adr_q == hpp_pkg::ADR_DIRECT0)
      |=> loc_q[0][15:0] == $past(data_q[15:0]))
    else $error("low word not written");
  a_read_drive: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (rd_act && lo_act) [*2] |-> host_data_oe_out[15:0] == 16'hFFFF)
    else $error("read data not driven");
  c_fifo_step: cover property (@(posedge ref_clk_in) fifo_step);
  c_ind_step: cover property (@(posedge ref_clk_in) ind_step);
  c_ack: cover property (@(posedge ref_clk_in) !host_ack_n_out);
endmodule

/* verilog/hpp_pkg.sv */
package hpp_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned NUM_LOC = 4;
  // Dword address codes for the four direct locations (byte 0x00, 0x04, 0x08, 0x0C).
  localparam logic [1:0] ADR_DIRECT0 = 2'h0;
  localparam logic [1:0] ADR_INDIRECT_ADDR = 2'h1;
  localparam logic [1:0] ADR_INDIRECT_DATA = 2'h2;
  localparam logic [1:0] ADR_FIFO = 2'h3;
  localparam logic [7:0] LOC_BYTE_STEP = 8'h04;
  localparam logic [31:0] LOC_RESET = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int unsigned IND_PTR_W = 8;
  localparam logic [7:0] IND_PTR_RESET = 8'h00;
  localparam logic [7:0] IND_PTR_STEP = 8'h01;
  localparam int unsigned FIFO_PTR_W = 9;
  localparam logic [8:0] FIFO_PTR_RESET = 9'h000;
  localparam logic [8:0] FIFO_PTR_STEP = 9'h001;
  typedef enum logic [1:0] {HPP_IDLE, HPP_WAIT, HPP_ACK} hpp_state_t;
endpackage

/* testbench/hpp_host_model.sv */
`timescale 1ns/1ps
module hpp_host_model
(
  input  wire logic        clk_in,
  input  wire logic        ack_n_in,
  input  wire logic [31:0] rd_data_in,
  output logic      [1:0]  adr_out,
  output logic      [31:0] wr_data_out,
  output logic             cs_n_out,
  output logic             wr_n_out,
  output logic             rd_n_out,
  output logic             le_n_out,
  output logic             he_n_out
);
  initial
  begin
    adr_out = 2'h0;
    wr_data_out = 32'h0000_0000;
    {cs_n_out, wr_n_out, rd_n_out, le_n_out, he_n_out} = 5'h1f;
  end
  // Enables are passed as {high, low}, both low for a 32-bit access.
  task automatic acc(input logic wr, input logic [1:0] adr, input logic [1:0] en_n,
                     input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(negedge clk_in);
    adr_out = adr;
    {he_n_out, le_n_out} = en_n;
    cs_n_out = 1'b0;
    wr_data_out = wd;
    wr_n_out = !wr;
    rd_n_out = wr;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (ack_n_in !== 1'b0 && n < 200);
    rd = rd_data_in;
    ok = (n < 200);
    @(negedge clk_in);
    // Strobe goes first; select and enables stay until the acknowledge clears.
    {wr_n_out, rd_n_out} = 2'b11;
    wr_data_out = ~wd;
    n = 0;
    while (ack_n_in !== 1'b1 && n < 20)
    begin
      @(negedge clk_in);
      n++;
    end
    {cs_n_out, le_n_out, he_n_out} = 3'h7;
    // The enable release is seen two cycles late, so pointers move after this point.
    repeat (5) @(negedge clk_in);
  endtask
  // Read strobe and enables without chip select.
  task automatic stray(input logic on);
    @(negedge clk_in);
    {rd_n_out, le_n_out, he_n_out} = {3{!on}};
  endtask
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, full, empty, enc, ok;
  logic cs_n, wr_n, rd_n, le_n, he_n, ack_n, push, pop;
  logic [1:0]  adr;
  logic [31:0] wd, dout, oe, fwd, rd, frd;
  logic [8:0]  fptr;
  logic [7:0]  iptr;
  int          fails, comparisons, pushes, pops;
  hpp_host_port dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .host_adr_in(adr),
    .host_data_in(wd), .host_data_out(dout), .host_data_oe_out(oe), .host_cs_n_in(cs_n),
    .host_wr_n_in(wr_n), .host_rd_n_in(rd_n), .low_word_enable_n_in(le_n),
    .high_word_enable_n_in(he_n), .host_ack_n_out(ack_n), .fifo_full_in(full),
    .fifo_empty_in(empty), .encode_mode_in(enc), .fifo_rd_data_in(frd),
    .fifo_push_out(push), .fifo_pop_out(pop), .fifo_wr_data_out(fwd),
    .fifo_ptr_out(fptr), .ind_ptr_out(iptr));
  hpp_host_model host_u (.clk_in(clk), .ack_n_in(ack_n), .rd_data_in(dout), .adr_out(adr),
    .wr_data_out(wd), .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n), .le_n_out(le_n),
    .he_n_out(he_n));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    pushes += (push === 1'b1);
    pops += (pop === 1'b1);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic t_direct;
    host_u.acc(1'b1, 2'h0, 2'b00, 32'ha5c3_1e87, rd, ok);
    host_u.acc(1'b0, 2'h0, 2'b00, 32'h0000_0000, rd, ok);
    check("direct", rd, 32'ha5c3_1e87);
    fork
      host_u.acc(1'b0, 2'h0, 2'b10, 32'h0000_0000, rd, ok);
      begin
        @(negedge ack_n);
        @(negedge clk);
        check("oe read", oe, 32'h0000_ffff);
      end
    join
    host_u.acc(1'b1, 2'h0, 2'b10, 32'h1111_2222, rd, ok);
    host_u.acc(1'b1, 2'h0, 2'b01, 32'h3333_4444, rd, ok);
    host_u.acc(1'b0, 2'h0, 2'b00, 32'h0000_0000, rd, ok);
    check("words", rd, 32'h3333_2222);
  endtask
  task automatic t_nocs;
    host_u.stray(1'b1);
    repeat (8) @(posedge clk);
    check("oe", oe, 32'h0000_0000);
    check("ack", {31'h0, ack_n}, 32'h0000_0001);
    host_u.stray(1'b0);
  endtask
  task automatic t_indirect;
    host_u.acc(1'b1, 2'h1, 2'b10, 32'h0000_0005, rd, ok);
    check("ind load", {24'h0, iptr}, 32'h0000_0005);
    host_u.acc(1'b1, 2'h2, 2'b01, 32'h0000_0000, rd, ok);
    check("ind hold", {24'h0, iptr}, 32'h0000_0005);
    host_u.acc(1'b0, 2'h2, 2'b10, 32'h0000_0000, rd, ok);
    check("ind step", {24'h0, iptr}, 32'h0000_0006);
  endtask
  task automatic t_fifo;
    host_u.acc(1'b1, 2'h3, 2'b10, 32'h0000_beef, rd, ok);
    check("fifo hold", {23'h0, fptr}, 32'h0000_0000);
    host_u.acc(1'b1, 2'h3, 2'b01, 32'hcafe_0000, rd, ok);
    check("fifo step", {23'h0, fptr}, 32'h0000_0001);
    check("push", pushes, 32'h0000_0001);
    check("fifo data", fwd, 32'hcafe_beef);
    @(negedge clk) full = 1'b1;
    fork
      host_u.acc(1'b1, 2'h3, 2'b00, 32'h1234_5678, rd, ok);
      begin
        repeat (30) @(posedge clk);
        check("held ack", {31'h0, ack_n}, 32'h0000_0001);
        @(negedge clk) full = 1'b0;
      end
    join
    check("late ack", {31'h0, ok}, 32'h0000_0001);
    check("push 2", pushes, 32'h0000_0002);
    @(negedge clk) enc = 1'b1;
    host_u.acc(1'b0, 2'h3, 2'b00, 32'h0000_0000, rd, ok);
    check("fifo read", rd, 32'h5a5a_0ff0);
    check("pop", pops, 32'h0000_0001);
    check("fifo ptr", {23'h0, fptr}, 32'h0000_0003);
  endtask
  task automatic t_empty;
    @(negedge clk) empty = 1'b1;
    fork
      host_u.acc(1'b0, 2'h3, 2'b00, 32'h0000_0000, rd, ok);
      begin
        repeat (30) @(posedge clk);
        check("empty ack", {31'h0, ack_n}, 32'h0000_0001);
        check("empty pop", pops, 32'h0000_0001);
        @(negedge clk) empty = 1'b0;
      end
    join
    check("empty late", {31'h0, ok}, 32'h0000_0001);
    check("pop 2", pops, 32'h0000_0002);
    check("empty ptr", {23'h0, fptr}, 32'h0000_0004);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test;
  end
  initial
  begin
    {rst, full, empty, enc} = 4'h8;
    frd = 32'h5a5a_0ff0;
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_direct;
    t_nocs;
    t_indirect;
    t_fifo;
    t_empty;
    stop_test;
  end
endmodule
